/* src/bmap_defines.svh */
// What this block does
// - Thirteen-bit program counter spans 8K words
// - Fetches above 07FFh wrap into implemented space
// - Reset loads 0000h, interrupt loads 0004h
// - Fetch path and data path run side by side; a data write to offset 02h loads the PC
// - Status bits 6:5 select banks 0-3
// - Each bank holds offsets 00h to 7Fh
// - Low offsets special registers, upper offsets RAM
// - Core registers mirrored, status in every bank
// - Offset 00h accesses through indirect pointer register
// - User code may read program memory internally
// - Upper PC bits load from pc_upper_latch
`ifndef BMAP_DEFINES_SVH
`define BMAP_DEFINES_SVH

// ===========================================================
// Widths
// ===========================================================
`define BMAP_PC_W          13
`define BMAP_PROG_AW       11
`define BMAP_OFF_W         7
`define BMAP_DADDR_W       9
`define BMAP_GPR_DEPTH     128

// ===========================================================
// Vectors
// ===========================================================
`define BMAP_RESET_VEC     13'h0000
`define BMAP_IRQ_VEC       13'h0004

// ===========================================================
// Register offsets within every bank
// ===========================================================
`define BMAP_OFF_INDIRECT  7'h00
`define BMAP_OFF_PC_LOW    7'h02
`define BMAP_OFF_STATUS    7'h03
`define BMAP_OFF_POINTER   7'h04
`define BMAP_OFF_PC_UPPER  7'h0a
`define BMAP_OFF_GPR_BASE  7'h20
`define BMAP_OFF_SHARED    7'h40

// ===========================================================
// Status field positions and reset values
// ===========================================================
`define BMAP_ST_IRP        7
`define BMAP_ST_BANK_HI    6
`define BMAP_ST_BANK_LO    5
`define BMAP_STATUS_RST    8'h18
`define BMAP_POINTER_RST   8'h00
`define BMAP_PC_UPPER_RST  5'h00

`endif

/* src/bmap_pkg.sv */
package bmap_pkg;

  // ===========================================================
  // Top-level state
  // ===========================================================
  typedef struct packed {
    logic [12:0] pc;
    logic [10:0] fetch_addr;
    logic [7:0]  status;
    logic [7:0]  pointer;
    logic [4:0]  upper_latch;
    logic [7:0]  rdata;
    logic [8:0]  data_addr;
    logic [10:0] prog_addr;
    logic        prog_valid;
  } map_state_type;

endpackage

/* src/gpr_alias_map.sv */
`timescale 1ns/10ps
`include "bmap_defines.svh"

module gpr_alias_map (
  input  wire logic [1:0] bank_i,
  input  wire logic [6:0] offset_i,
  output logic            is_gpr_o,
  output logic [6:0]      index_o
);

  // ===========================================================
  // Physical RAM index
  // ===========================================================
  // Odd banks below 40h own 32 bytes after bank 0's 96
  always_comb begin
    is_gpr_o = (offset_i >= `BMAP_OFF_GPR_BASE);
    if (bank_i[0] && (offset_i < `BMAP_OFF_SHARED)) begin
      index_o = offset_i + 7'h40;
    end else begin
      index_o = offset_i - `BMAP_OFF_GPR_BASE;
    end
  end

endmodule // gpr_alias_map

/* src/gpr_byte_store.sv */
`timescale 1ns/10ps

module gpr_byte_store #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] index_i,
  input  wire logic [7:0]    wdata_i,
  output logic [7:0]         rdata_o
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } store_type;

  store_type s;
  store_type next_s;

  // ===========================================================
  // Flop storage, read is combinational from the array
  // ===========================================================
  always_comb begin
    next_s = s;
    if (we_i) begin
      next_s.mem[index_i] = wdata_i;
    end
  end

  // Cleared at reset so reads never show unknowns
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.mem[index_i];

endmodule // gpr_byte_store

/* src/banked_memory_address_map.sv */
`timescale 1ns/10ps
`include "bmap_defines.svh"

module banked_memory_address_map (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Program side
  input  wire logic        pc_step_i,
  input  wire logic        pc_goto_i,
  input  wire logic [10:0] goto_addr_i,
  input  wire logic        irq_take_i,
  input  wire logic        prog_read_i,
  input  wire logic [12:0] prog_read_addr_i,
  output logic [12:0]      pc_o,
  output logic [10:0]      fetch_addr_o,
  output logic [10:0]      prog_read_addr_o,
  output logic             prog_read_valid_o,
  // Data side
  input  wire logic [6:0]  data_addr_i,
  input  wire logic [7:0]  data_wdata_i,
  input  wire logic        data_we_i,
  input  wire logic        data_re_i,
  output logic [7:0]       data_rdata_o,
  output logic [8:0]       data_addr_o
);

  bmap_pkg::map_state_type s;
  bmap_pkg::map_state_type next_s;

  logic       indirect;
  logic [1:0] eff_bank;
  logic [6:0] eff_off;
  logic       void_access;
  logic       is_gpr;
  logic [6:0] gpr_index;
  logic [7:0] gpr_rdata;
  logic       gpr_we;
  logic [7:0] reg_rdata;
  logic       pc_low_write;

  // ===========================================================
  // Address formation
  // ===========================================================
  // Offset 00h redirects through the pointer and status bit 7
  always_comb begin
    indirect = (data_addr_i == `BMAP_OFF_INDIRECT);
    if (indirect) begin
      eff_bank = {s.status[`BMAP_ST_IRP], s.pointer[7]};
      eff_off  = s.pointer[6:0];
    end else begin
      eff_bank = {s.status[`BMAP_ST_BANK_HI], s.status[`BMAP_ST_BANK_LO]};
      eff_off  = data_addr_i;
    end
  end

  // Pointer aimed at itself reads zero and drops writes
  assign void_access = (eff_off == `BMAP_OFF_INDIRECT);

  gpr_alias_map u_alias (
    .bank_i   (eff_bank),
    .offset_i (eff_off),
    .is_gpr_o (is_gpr),
    .index_o  (gpr_index)
  );

  assign gpr_we = data_we_i && is_gpr;

  gpr_byte_store #(
    .DEPTH (`BMAP_GPR_DEPTH),
    .AW    (7)
  ) u_store (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .we_i    (gpr_we),
    .index_i (gpr_index),
    .wdata_i (data_wdata_i),
    .rdata_o (gpr_rdata)
  );

  // ===========================================================
  // Read mux for the low offsets
  // ===========================================================
  // Core registers decode without the bank bits, so all banks see them
  always_comb begin
    reg_rdata = 8'h00;
    if (is_gpr) begin
      reg_rdata = gpr_rdata;
    end else if (!void_access) begin
      case (eff_off)
        `BMAP_OFF_PC_LOW:   reg_rdata = s.pc[7:0];
        `BMAP_OFF_STATUS:   reg_rdata = s.status;
        `BMAP_OFF_POINTER:  reg_rdata = s.pointer;
        `BMAP_OFF_PC_UPPER: reg_rdata = {3'h0, s.upper_latch};
        default:            reg_rdata = 8'h00; // Peripheral slots read zero
      endcase
    end
  end

  assign pc_low_write = data_we_i && !void_access && (eff_off == `BMAP_OFF_PC_LOW);

  // ===========================================================
  // Next state
  // ===========================================================
  always_comb begin
    next_s = s;
    // Data path, independent of the fetch path below
    if (data_we_i && !void_access) begin
      case (eff_off)
        `BMAP_OFF_STATUS:   next_s.status      = data_wdata_i;
        `BMAP_OFF_POINTER:  next_s.pointer     = data_wdata_i;
        `BMAP_OFF_PC_UPPER: next_s.upper_latch = data_wdata_i[4:0];
        default:            next_s.pointer     = s.pointer;
      endcase
    end
    if (data_re_i) begin
      next_s.rdata = reg_rdata;
    end
    if (data_re_i || data_we_i) begin
      next_s.data_addr = {eff_bank, eff_off};
    end
    // Program counter, interrupt wins over every other load
    if (irq_take_i) begin
      next_s.pc = `BMAP_IRQ_VEC;
    end else if (pc_low_write) begin
      next_s.pc = {s.upper_latch, data_wdata_i};
    end else if (pc_goto_i) begin
      next_s.pc = {s.upper_latch[4:3], goto_addr_i};
    end else if (pc_step_i) begin
      next_s.pc = s.pc + 13'h0001;
    end
    // Upper two counter bits are kept but never decoded
    next_s.fetch_addr = next_s.pc[10:0];
    // Table reads run beside the fetch on their own address
    next_s.prog_valid = prog_read_i;
    if (prog_read_i) begin
      next_s.prog_addr = prog_read_addr_i[10:0];
    end
  end

  // ===========================================================
  // State register
  // ===========================================================
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s            <= '0;
      s.pc         <= `BMAP_RESET_VEC;
      s.fetch_addr <= 11'h000;
      s.status     <= `BMAP_STATUS_RST;
      s.pointer    <= `BMAP_POINTER_RST;
      s.upper_latch <= `BMAP_PC_UPPER_RST;
    end else begin
      s <= next_s;
    end
  end

  // ===========================================================
  // Outputs straight from the state flops
  // ===========================================================
  assign pc_o              = s.pc;
  assign fetch_addr_o      = s.fetch_addr;
  assign prog_read_addr_o  = s.prog_addr;
  assign prog_read_valid_o = s.prog_valid;
  assign data_rdata_o      = s.rdata;
  assign data_addr_o       = s.data_addr;

  // ===========================================================
  // Checks
  // ===========================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Interrupt vector lands one cycle after the request
  a_irq_vector_load: assert property (
    irq_take_i |=> (pc_o == `BMAP_IRQ_VEC))
    else $error("pc not at interrupt vector");

  // Fetch address is always the counter folded to 2K
  a_fetch_wrap_fold: assert property (
    fetch_addr_o == pc_o[10:0])
    else $error("fetch address not wrapped");

  // Plain step advances by exactly one
  a_pc_step_one: assert property (
    (pc_step_i && !pc_goto_i && !irq_take_i && !pc_low_write)
      |=> (pc_o == $past(pc_o) + 13'h0001))
    else $error("pc step wrong");

  // Writing the low byte pulls the upper bits from the latch
  a_pc_low_load: assert property (
    (pc_low_write && !irq_take_i)
      |=> (pc_o == {$past(s.upper_latch), $past(data_wdata_i)}))
    else $error("pc upper bits not from latch");

  // Direct address carries the bank bits above the offset
  a_direct_bank_form: assert property (
    ((data_re_i || data_we_i) && (data_addr_i != 7'h00))
      |=> (data_addr_o == {$past(s.status[6:5]), $past(data_addr_i)}))
    else $error("direct address malformed");

  // Indirect address comes from irp and the pointer
  a_indirect_form: assert property (
    ((data_re_i || data_we_i) && (data_addr_i == 7'h00))
      |=> (data_addr_o == {$past(s.status[7]), $past(s.pointer)}))
    else $error("indirect address malformed");

  // Status write from any bank updates the one register
  a_status_mirror: assert property (
    (data_we_i && (data_addr_i == `BMAP_OFF_STATUS))
      |=> (s.status == $past(data_wdata_i)))
    else $error("status write lost");

  // Status reads back the same in every bank
  a_status_read: assert property (
    (data_re_i && (data_addr_i == `BMAP_OFF_STATUS))
      |=> (data_rdata_o == $past(s.status)))
    else $error("status read wrong");

  // Table read returns the folded address next cycle
  a_prog_read_addr: assert property (
    prog_read_i
      |=> (prog_read_valid_o && (prog_read_addr_o == $past(prog_read_addr_i[10:0]))))
    else $error("program read address wrong");

  // Data access never delays a simultaneous program read
  a_concurrent_paths: assert property (
    (prog_read_i && (data_re_i || data_we_i)) |=> prog_read_valid_o)
    else $error("program read blocked by data access");

  // Bank 2 RAM writes land in bank 0 RAM
  a_bank2_alias: assert property (
    (data_we_i && (data_addr_i >= 7'h20) && (s.status[6:5] == 2'h2))
      |=> (u_store.s.mem[$past(data_addr_i) - 7'h20] == $past(data_wdata_i)))
    else $error("bank 2 alias wrong");

  // Low offsets never touch RAM
  a_low_region: assert property (
    (data_we_i && (eff_off < `BMAP_OFF_GPR_BASE)) |-> !gpr_we)
    else $error("special register slot wrote RAM");

  // ===========================================================
  // Hold and decode checks
  // ===========================================================
  // Interrupt also moves the fetch address to the vector
  a_irq_fetch_vector: assert property (
    irq_take_i |=> ({2'h0, fetch_addr_o} == `BMAP_IRQ_VEC))
    else $error("fetch address not at interrupt vector");

  // Jump keeps the latch's two top bits above the target
  a_goto_target_load: assert property (
    (pc_goto_i && !irq_take_i && !pc_low_write)
      |=> (pc_o == {$past(s.upper_latch[4:3]), $past(goto_addr_i)}))
    else $error("jump target wrong");

  // With no load request the counter stays put
  a_pc_hold_idle: assert property (
    (!pc_step_i && !pc_goto_i && !irq_take_i && !pc_low_write)
      |=> $stable(pc_o))
    else $error("pc moved without a request");

  // Valid is a single-cycle echo of the request
  a_prog_valid_pulse: assert property (
    !prog_read_i |=> !prog_read_valid_o)
    else $error("program read valid without request");

  // Program read address holds between requests
  a_prog_addr_hold: assert property (
    !prog_read_i |=> $stable(prog_read_addr_o))
    else $error("program read address moved");

  // Read data only changes on a read strobe
  a_rdata_hold: assert property (
    !data_re_i |=> $stable(data_rdata_o))
    else $error("read data moved without read");

  // Effective address only changes on an access
  a_data_addr_hold: assert property (
    !(data_re_i || data_we_i) |=> $stable(data_addr_o))
    else $error("data address moved without access");

  // Pointer write lands from any bank
  a_pointer_write: assert property (
    (data_we_i && (data_addr_i == `BMAP_OFF_POINTER))
      |=> (s.pointer == $past(data_wdata_i)))
    else $error("pointer write lost");

  // Latch keeps the low five bits written
  a_latch_write: assert property (
    (data_we_i && (data_addr_i == `BMAP_OFF_PC_UPPER))
      |=> (s.upper_latch == $past(data_wdata_i[4:0])))
    else $error("upper latch write lost");

  // Latch reads back with its three top bits clear
  a_latch_read: assert property (
    (data_re_i && (data_addr_i == `BMAP_OFF_PC_UPPER))
      |=> (data_rdata_o == {3'h0, $past(s.upper_latch)}))
    else $error("upper latch read wrong");

  // Counter low byte readable in every bank
  a_pc_low_read: assert property (
    (data_re_i && (data_addr_i == `BMAP_OFF_PC_LOW))
      |=> (data_rdata_o == $past(pc_o[7:0])))
    else $error("pc low byte read wrong");

  // Pointer aimed at the indirect slot reads zero
  a_void_read_zero: assert property (
    (data_re_i && (data_addr_i == `BMAP_OFF_INDIRECT) && (s.pointer[6:0] == 7'h00))
      |=> (data_rdata_o == 8'h00))
    else $error("indirect self access not zero");

  // Indirect write can reach the status register
  a_status_indirect: assert property (
    (data_we_i && (data_addr_i == `BMAP_OFF_INDIRECT)
      && (s.pointer[6:0] == `BMAP_OFF_STATUS))
      |=> (s.status == $past(data_wdata_i)))
    else $error("indirect status write lost");

  // Peripheral slots above the core registers read zero
  a_periph_read_zero: assert property (
    (data_re_i && (data_addr_i > `BMAP_OFF_POINTER)
      && (data_addr_i < `BMAP_OFF_GPR_BASE) && (data_addr_i != `BMAP_OFF_PC_UPPER))
      |=> (data_rdata_o == 8'h00))
    else $error("peripheral slot not zero");

  // Any RAM write is stored at the decoded index
  a_ram_write_lands: assert property (
    gpr_we |=> (u_store.s.mem[$past(gpr_index)] == $past(data_wdata_i)))
    else $error("RAM write not stored");

  // Odd banks below the shared part use the top 32 bytes
  a_odd_bank_own: assert property (
    (is_gpr && eff_bank[0] && (eff_off < `BMAP_OFF_SHARED))
      |-> (gpr_index == {2'h3, eff_off[4:0]}))
    else $error("odd bank private RAM misplaced");

  // Shared upper part always lands in bank 0's upper 64 bytes
  a_shared_upper: assert property (
    (is_gpr && (eff_off >= `BMAP_OFF_SHARED))
      |-> ((gpr_index >= 7'h20) && (gpr_index <= 7'h5f)))
    else $error("shared RAM misplaced");

endmodule // banked_memory_address_map

/* dv/core_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Core-side model: fetch control and data accesses
// ==========================================================
module core_model (
  input  wire logic   clk_i,
  output logic        step_o,
  output logic        goto_o,
  output logic [10:0] goto_addr_o,
  output logic        irq_o,
  output logic        pread_o,
  output logic [12:0] pread_addr_o,
  output logic [6:0]  daddr_o,
  output logic [7:0]  wdata_o,
  output logic        we_o,
  output logic        re_o
);
  // Everything quiet at time zero
  initial begin
    {step_o, goto_o, irq_o, pread_o, we_o, re_o} = 6'h00;
    {goto_addr_o, pread_addr_o} = 24'h000000;
    {daddr_o, wdata_o} = 15'h0000;
  end

  // One data access; idle lines go inverted so stale values never pass
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    daddr_o <= a;
    wdata_o <= d;
    we_o    <= w;
    re_o    <= !w;
    @(posedge clk_i);
    we_o    <= 1'b0;
    re_o    <= 1'b0;
    daddr_o <= ~a;
    wdata_o <= ~d;
    #1;
  endtask

  // Program-side request: 0 step, 1 jump, 2 interrupt, 3 program read
  task automatic prog(input logic [1:0] k, input logic [12:0] a);
    @(posedge clk_i);
    step_o       <= (k == 2'h0);
    goto_o       <= (k == 2'h1);
    irq_o        <= (k == 2'h2);
    pread_o      <= (k == 2'h3);
    goto_addr_o  <= a[10:0];
    pread_addr_o <= a;
    @(posedge clk_i);
    {step_o, goto_o, irq_o, pread_o} <= 4'h0;
    #1;
  endtask
endmodule // core_model

/* dv/banked_memory_address_map_tb.sv */
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench
// ==========================================================
module banked_memory_address_map_tb;
  logic        clk_i;
  logic        rstn_i;
  logic        step, go, irq, pread, we, re, pvalid;
  logic [10:0] gaddr, fetch, paddr_o;
  logic [12:0] paddr, pc;
  logic [6:0]  daddr;
  logic [7:0]  wdata, rdata;
  logic [8:0]  eaddr;
  int          failures;
  int          n_checks;

  core_model core (.clk_i(clk_i), .step_o(step), .goto_o(go), .goto_addr_o(gaddr),
    .irq_o(irq), .pread_o(pread), .pread_addr_o(paddr), .daddr_o(daddr),
    .wdata_o(wdata), .we_o(we), .re_o(re));

  banked_memory_address_map dut (.clk_i(clk_i), .rstn_i(rstn_i), .pc_step_i(step),
    .pc_goto_i(go), .goto_addr_i(gaddr), .irq_take_i(irq), .prog_read_i(pread),
    .prog_read_addr_i(paddr), .pc_o(pc), .fetch_addr_o(fetch),
    .prog_read_addr_o(paddr_o), .prog_read_valid_o(pvalid), .data_addr_i(daddr),
    .data_wdata_i(wdata), .data_we_i(we), .data_re_i(re), .data_rdata_o(rdata),
    .data_addr_o(eaddr));

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    core.access(1'b1, a, d);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    core.access(1'b0, a, 8'h00);
    check("rdata", 16'(rdata), 16'(e));
  endtask

  // Whole run is well under 2000 cycles; this only cuts a hang short
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    failures = 0;
    n_checks = 0;
    rstn_i   = 1'b0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    check("pc", 16'(pc), 16'h0000);
    rd(7'h03, 8'h18);
    rd(7'h04, 8'h00);
    rd(7'h0a, 8'h00);
    $display("test reset done");
    // Status mirrored in every bank, bank bits lead the address
    for (int b = 0; b < 4; b++) begin
      wr(7'h03, {1'b0, 2'(b), 5'h18});
      rd(7'h03, {1'b0, 2'(b), 5'h18});
      check("eaddr", 16'(eaddr), 16'({2'(b), 7'h03}));
    end
    $display("test banks done");
    // RAM aliasing; bank1 low RAM is its own, upper RAM is shared
    wr(7'h03, 8'h18);
    wr(7'h21, 8'ha1);
    wr(7'h03, 8'h38);
    wr(7'h21, 8'hb1);
    wr(7'h05, 8'hff);
    rd(7'h05, 8'h00);
    wr(7'h03, 8'h58);
    rd(7'h21, 8'ha1);
    wr(7'h03, 8'h78);
    rd(7'h21, 8'hb1);
    wr(7'h7f, 8'hc3);
    wr(7'h03, 8'h18);
    rd(7'h7f, 8'hc3);
    $display("test ram done");
    // Indirect access, including a pointer into bank 1
    wr(7'h04, 8'h21);
    rd(7'h00, 8'ha1);
    wr(7'h04, 8'ha1);
    wr(7'h00, 8'h5a);
    wr(7'h03, 8'h38);
    rd(7'h21, 8'h5a);
    wr(7'h03, 8'h18);
    rd(7'h21, 8'ha1);
    $display("test indirect done");
    // Program counter loads, wrap and program reads
    core.prog(2'h2, 13'h0000);
    check("pc", 16'(pc), 16'h0004);
    wr(7'h0a, 8'h1f);
    core.prog(2'h1, 13'h07ff);
    check("pc", 16'(pc), 16'h1fff);
    check("fetch", 16'(fetch), 16'h07ff);
    core.prog(2'h0, 13'h0000);
    check("pc", 16'(pc), 16'h0000);
    wr(7'h02, 8'h34);
    check("pc", 16'(pc), 16'h1f34);
    check("fetch", 16'(fetch), 16'h0734);
    core.prog(2'h3, 13'h1abc);
    check("pvalid", 16'(pvalid), 16'h0001);
    check("paddr", 16'(paddr_o), 16'h02bc);
    @(posedge clk_i);
    #1;
    check("pvalid", 16'(pvalid), 16'h0000);
    // Fetch and data access in the same cycle
    fork
      core.prog(2'h0, 13'h0000);
      core.access(1'b0, 7'h21, 8'h00);
    join
    check("pc", 16'(pc), 16'h1f35);
    check("rdata", 16'(rdata), 16'h00a1);
    $display("test program done");
    report_and_stop();
  end
endmodule // banked_memory_address_map_tb
